/* File: design/aux_output_function_selector.sv */
// Function selector for the drive's second auxiliary output, APB slave.
`timescale 1ns/1ps
`default_nettype none
module aux_output_function_selector #(
  parameter int UPDATE_CYCLES = aux_out_pkg::UPDATE_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic drive_enabled,
  input wire logic drive_running,
  input wire logic drive_fault,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] setpoint_freq,
  input wire logic [15:0] motor_current,
  input wire logic [15:0] motor_torque,
  input wire logic [15:0] analog_in2,
  output logic aux_digital_out,
  output logic aux_analog_mode,
  output logic [15:0] aux_analog_value,
  output logic [1:0] aux_format
);
  localparam logic [15:0] DIV_LAST = 16'(UPDATE_CYCLES - 1);

  logic [3:0] aux_output2_function_select_reg;
  logic [3:0] aux_output2_function_select_next;
  logic [1:0] aux_output2_format_select_reg;
  logic [1:0] aux_output2_format_select_next;
  logic [15:0] upper_threshold_setting_reg;
  logic [15:0] upper_threshold_setting_next;
  logic [15:0] lower_threshold_setting_reg;
  logic [15:0] lower_threshold_setting_next;
  logic [15:0] motor_rated_current_setting_reg;
  logic [15:0] motor_rated_current_setting_next;
  logic [15:0] max_freq_setting_reg;
  logic [15:0] max_freq_setting_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic [15:0] div_reg;
  logic [15:0] div_next;
  logic dig_reg;
  logic dig_next;
  logic mode_reg;
  logic mode_next;
  logic [15:0] aval_reg;
  logic [15:0] aval_next;
  logic [3:0] seen_reg;
  logic [3:0] seen_next;

  logic tick;
  logic wr_en;
  logic addr_hit;
  logic thr_sel;
  logic sel_changed;
  logic hyst_prev;
  logic hyst_next;
  logic [15:0] cmp_qty;
  logic [3:0] fsel;

  scale_if sc ();

  assign fsel = aux_output2_function_select_reg;
  assign tick = (div_reg == DIV_LAST);

  // Update-rate divider.
  always_comb begin
    div_next = tick ? 16'h0000 : div_reg + 16'h0001;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_next;
    end
  end

  // APB slave: zero wait states, error on an unmapped address.
  always_comb begin
    case (paddr)
      aux_out_pkg::OFS_FUNC,
      aux_out_pkg::OFS_FORMAT,
      aux_out_pkg::OFS_UPPER,
      aux_out_pkg::OFS_LOWER,
      aux_out_pkg::OFS_RATED_CUR,
      aux_out_pkg::OFS_MAX_FREQ,
      aux_out_pkg::OFS_STATUS: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;
  assign wr_en = psel & penable & pwrite;
  assign prdata = prdata_reg;

  always_comb begin
    aux_output2_function_select_next = aux_output2_function_select_reg;
    aux_output2_format_select_next = aux_output2_format_select_reg;
    upper_threshold_setting_next = upper_threshold_setting_reg;
    lower_threshold_setting_next = lower_threshold_setting_reg;
    motor_rated_current_setting_next = motor_rated_current_setting_reg;
    max_freq_setting_next = max_freq_setting_reg;
    if (wr_en) begin
      case (paddr)
        aux_out_pkg::OFS_FUNC: begin
          aux_output2_function_select_next = pwdata[3:0];
        end
        aux_out_pkg::OFS_FORMAT: begin
          aux_output2_format_select_next = pwdata[1:0];
        end
        aux_out_pkg::OFS_UPPER: upper_threshold_setting_next = pwdata[15:0];
        aux_out_pkg::OFS_LOWER: lower_threshold_setting_next = pwdata[15:0];
        aux_out_pkg::OFS_RATED_CUR: begin
          motor_rated_current_setting_next = pwdata[15:0];
        end
        aux_out_pkg::OFS_MAX_FREQ: max_freq_setting_next = pwdata[15:0];
        default: begin
        end
      endcase
    end
    prdata_next = prdata_reg;
    // Read data is latched in the setup cycle and stands in the access.
    if (psel && !penable) begin
      prdata_next = 32'h00000000;
      case (paddr)
        aux_out_pkg::OFS_FUNC: prdata_next[3:0] = fsel;
        aux_out_pkg::OFS_FORMAT: begin
          prdata_next[1:0] = aux_output2_format_select_reg;
        end
        aux_out_pkg::OFS_UPPER: begin
          prdata_next[15:0] = upper_threshold_setting_reg;
        end
        aux_out_pkg::OFS_LOWER: begin
          prdata_next[15:0] = lower_threshold_setting_reg;
        end
        aux_out_pkg::OFS_RATED_CUR: begin
          prdata_next[15:0] = motor_rated_current_setting_reg;
        end
        aux_out_pkg::OFS_MAX_FREQ: prdata_next[15:0] = max_freq_setting_reg;
        aux_out_pkg::OFS_STATUS: begin
          prdata_next[aux_out_pkg::STAT_DIG_BIT] = dig_reg;
          prdata_next[aux_out_pkg::STAT_MODE_BIT] = mode_reg;
          prdata_next[31:16] = aval_reg;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aux_output2_function_select_reg <= aux_out_pkg::FUNC_RESET;
      aux_output2_format_select_reg <= aux_out_pkg::FMT_RESET;
      upper_threshold_setting_reg <= aux_out_pkg::QTY_RESET;
      lower_threshold_setting_reg <= aux_out_pkg::QTY_RESET;
      motor_rated_current_setting_reg <= aux_out_pkg::QTY_RESET;
      max_freq_setting_reg <= aux_out_pkg::QTY_RESET;
      prdata_reg <= 32'h00000000;
    end else begin
      aux_output2_function_select_reg <= aux_output2_function_select_next;
      aux_output2_format_select_reg <= aux_output2_format_select_next;
      upper_threshold_setting_reg <= upper_threshold_setting_next;
      lower_threshold_setting_reg <= lower_threshold_setting_next;
      motor_rated_current_setting_reg <= motor_rated_current_setting_next;
      max_freq_setting_reg <= max_freq_setting_next;
      prdata_reg <= prdata_next;
    end
  end

  // Quantity under comparison in the threshold selections.
  always_comb begin
    thr_sel = 1'b1;
    case (fsel)
      aux_out_pkg::SEL_FREQ_LIMIT: cmp_qty = out_freq;
      aux_out_pkg::SEL_CUR_LIMIT: cmp_qty = motor_current;
      aux_out_pkg::SEL_TORQUE_LIMIT: cmp_qty = motor_torque;
      aux_out_pkg::SEL_AIN2_LIMIT: cmp_qty = analog_in2;
      default: begin
        cmp_qty = aux_out_pkg::QTY_RESET;
        thr_sel = 1'b0;
      end
    endcase
  end

  // A freshly chosen source starts from a cleared hysteresis state.
  assign sel_changed = (fsel != seen_reg);
  assign hyst_prev = sel_changed ? 1'b0 : dig_reg;

  hyst_step #(.W(aux_out_pkg::QW)) u_hyst (
    .value(cmp_qty),
    .upper(upper_threshold_setting_reg),
    .lower(lower_threshold_setting_reg),
    .prev(hyst_prev),
    .next(hyst_next)
  );

  // Analog source and its full-scale range.
  always_comb begin
    case (fsel)
      aux_out_pkg::SEL_ANALOG_FREQ: begin
        sc.value = out_freq;
        sc.range = {1'b0, max_freq_setting_reg};
      end
      aux_out_pkg::SEL_ANALOG_CUR: begin
        sc.value = motor_current;
        sc.range = {motor_rated_current_setting_reg, 1'b0};
      end
      aux_out_pkg::SEL_ANALOG_TORQUE: begin
        sc.value = motor_torque;
        sc.range = aux_out_pkg::TORQUE_RANGE;
      end
      default: begin
        sc.value = aux_out_pkg::QTY_RESET;
        sc.range = 17'h00000;
      end
    endcase
  end

  saturating_scaler u_scale (
    .sc(sc)
  );

  // Output stage, refreshed once per update tick.
  always_comb begin
    dig_next = dig_reg;
    mode_next = mode_reg;
    aval_next = aval_reg;
    seen_next = seen_reg;
    if (tick) begin
      seen_next = fsel;
      mode_next = (fsel >= aux_out_pkg::SEL_ANALOG_FREQ);
      aval_next = mode_next ? sc.result : aux_out_pkg::QTY_RESET;
      case (fsel)
        aux_out_pkg::SEL_RUNNING: begin
          dig_next = drive_enabled & drive_running;
        end
        aux_out_pkg::SEL_HEALTHY: dig_next = ~drive_fault;
        aux_out_pkg::SEL_AT_TARGET: begin
          dig_next = (out_freq == setpoint_freq);
        end
        aux_out_pkg::SEL_ABOVE_ZERO: begin
          dig_next = (out_freq != aux_out_pkg::QTY_RESET);
        end
        default: dig_next = thr_sel & hyst_next;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dig_reg <= 1'b0;
      mode_reg <= 1'b0;
      aval_reg <= aux_out_pkg::QTY_RESET;
      seen_reg <= aux_out_pkg::FUNC_RESET;
    end else begin
      dig_reg <= dig_next;
      mode_reg <= mode_next;
      aval_reg <= aval_next;
      seen_reg <= seen_next;
    end
  end

  assign aux_digital_out = dig_reg;
  assign aux_analog_mode = mode_reg;
  assign aux_analog_value = aval_reg;
  assign aux_format = aux_output2_format_select_reg;

  property p_running;
    @(posedge clk) disable iff (!rstn)
    tick && fsel == 4'h0 |=> dig_reg == $past(drive_enabled && drive_running);
  endproperty
  a_running: assert property (p_running)
    else $error("Running status not reflected.");

  property p_healthy;
    @(posedge clk) disable iff (!rstn)
    tick && fsel == 4'h1 |=> dig_reg == !$past(drive_fault);
  endproperty
  a_healthy: assert property (p_healthy)
    else $error("Healthy status not reflected.");

  property p_target;
    @(posedge clk) disable iff (!rstn)
    tick && fsel == 4'h2 |=>
    dig_reg == ($past(out_freq) == $past(setpoint_freq));
  endproperty
  a_target: assert property (p_target)
    else $error("At-target status not reflected.");

  property p_zero;
    @(posedge clk) disable iff (!rstn)
    tick && fsel == 4'h3 |=> dig_reg == ($past(out_freq) != 16'h0000);
  endproperty
  a_zero: assert property (p_zero)
    else $error("Above-zero status not reflected.");

  property p_set;
    @(posedge clk) disable iff (!rstn)
    tick && thr_sel && cmp_qty > upper_threshold_setting_reg |=> dig_reg;
  endproperty
  a_set: assert property (p_set)
    else $error("Output not set above upper threshold.");

  property p_clear;
    @(posedge clk) disable iff (!rstn)
    tick && thr_sel && cmp_qty < lower_threshold_setting_reg &&
    !(cmp_qty > upper_threshold_setting_reg) |=> !dig_reg;
  endproperty
  a_clear: assert property (p_clear)
    else $error("Output not cleared below lower threshold.");

  property p_hold;
    @(posedge clk) disable iff (!rstn)
    tick && thr_sel && !sel_changed && dig_reg &&
    !(cmp_qty < lower_threshold_setting_reg) |=> dig_reg;
  endproperty
  a_hold: assert property (p_hold)
    else $error("Output dropped inside hysteresis band.");

  property p_mode;
    @(posedge clk) disable iff (!rstn)
    tick |=> aux_analog_mode == ($past(fsel) >= 4'h8) &&
    (aux_analog_mode || aux_analog_value == 16'h0000);
  endproperty
  a_mode: assert property (p_mode)
    else $error("Analog mode does not follow selection.");

  property p_freq_full;
    @(posedge clk) disable iff (!rstn)
    tick && fsel == 4'h8 && out_freq != 16'h0000 &&
    out_freq >= max_freq_setting_reg |=>
    aux_analog_value == 16'hFFFF;
  endproperty
  a_freq_full: assert property (p_freq_full)
    else $error("Frequency at maximum is not full scale.");

  property p_cur_full;
    @(posedge clk) disable iff (!rstn)
    tick && fsel == 4'h9 && motor_current != 16'h0000 &&
    {1'b0, motor_current} >= {motor_rated_current_setting_reg, 1'b0} |=>
    aux_analog_value == 16'hFFFF;
  endproperty
  a_cur_full: assert property (p_cur_full)
    else $error("Current at 200 percent is not full scale.");

  property p_torque_full;
    @(posedge clk) disable iff (!rstn)
    tick && fsel == 4'hA && motor_torque >= 16'h0672 |=>
    aux_analog_value == 16'hFFFF;
  endproperty
  a_torque_full: assert property (p_torque_full)
    else $error("Torque at 165 percent is not full scale.");

  property p_quiet;
    @(posedge clk) disable iff (!rstn)
    !tick |=> $stable(dig_reg) && $stable(aval_reg) && $stable(mode_reg);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("Output changed between update ticks.");

  property p_newsel;
    @(posedge clk) disable iff (!rstn)
    tick |=> seen_reg == $past(fsel) ##[1:UPDATE_CYCLES] tick;
  endproperty
  a_newsel: assert property (p_newsel)
    else $error("Selection not taken at update tick.");

  c_hyst_set: cover property (@(posedge clk) disable iff (!rstn)
    thr_sel && !dig_reg ##1 dig_reg);
  c_hyst_clr: cover property (@(posedge clk) disable iff (!rstn)
    thr_sel && dig_reg ##1 !dig_reg);
  c_analog_full: cover property (@(posedge clk) disable iff (!rstn)
    aux_analog_mode && aux_analog_value == 16'hFFFF);
  c_bad_addr: cover property (@(posedge clk) disable iff (!rstn) pslverr);
endmodule
`default_nettype wire

/* File: include/aux_out_pkg.sv */
// Constants shared by the auxiliary output selector and its helpers.
//
// Contract
// - Selection 0: high while enabled and running.
// - Selection 1: high while no fault present.
// - Selection 2: high while frequency equals setpoint.
// - Selection 3: high while output frequency above zero.
// - Selections 4 to 7 compare against thresholds.
// - Threshold mode: set above upper threshold.
// - Threshold mode: hold until below lower threshold.
// - Selection 5 compares motor output current.
// - Selection 7 compares second analog input.
// - Selection 8 upward: analog mode, separate format.
// - Selection 8: frequency zero to maximum, linear.
// - Current analog: full scale is 200% rated.
// - Selection 10: full scale is 165% torque.
`default_nettype none
package aux_out_pkg;
  localparam int QW = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FUNC_W = 4;
  localparam int FMT_W = 2;
  localparam logic [ADDR_W-1:0] OFS_FUNC = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FORMAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_UPPER = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LOWER = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_RATED_CUR = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MAX_FREQ = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
  localparam int STAT_DIG_BIT = 0;
  localparam int STAT_MODE_BIT = 1;
  localparam int STAT_VAL_LSB = 16;
  localparam logic [FUNC_W-1:0] FUNC_RESET = 4'h0;
  localparam logic [FMT_W-1:0] FMT_RESET = 2'h0;
  localparam logic [QW-1:0] QTY_RESET = 16'h0000;
  localparam logic [FUNC_W-1:0] SEL_RUNNING = 4'h0;
  localparam logic [FUNC_W-1:0] SEL_HEALTHY = 4'h1;
  localparam logic [FUNC_W-1:0] SEL_AT_TARGET = 4'h2;
  localparam logic [FUNC_W-1:0] SEL_ABOVE_ZERO = 4'h3;
  localparam logic [FUNC_W-1:0] SEL_FREQ_LIMIT = 4'h4;
  localparam logic [FUNC_W-1:0] SEL_CUR_LIMIT = 4'h5;
  localparam logic [FUNC_W-1:0] SEL_TORQUE_LIMIT = 4'h6;
  localparam logic [FUNC_W-1:0] SEL_AIN2_LIMIT = 4'h7;
  localparam logic [FUNC_W-1:0] SEL_ANALOG_FREQ = 4'h8;
  localparam logic [FUNC_W-1:0] SEL_ANALOG_CUR = 4'h9;
  localparam logic [FUNC_W-1:0] SEL_ANALOG_TORQUE = 4'hA;
  localparam logic [QW-1:0] FULL_SCALE = 16'hFFFF;
  // Torque arrives in tenths of a percent of rated torque.
  localparam logic [QW:0] TORQUE_RANGE = 17'h00672;
  localparam int CLK_PERIOD_NS = 20;
  localparam int UPDATE_PERIOD_NS = 1000;
  localparam int UPDATE_CYCLES = UPDATE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 16;
endpackage
`default_nettype wire

/* File: include/scale_if.sv */
// Interface carrying a quantity and its range to the saturating scaler.
`timescale 1ns/1ps
`default_nettype none
interface scale_if;
  logic [aux_out_pkg::QW-1:0] value;
  logic [aux_out_pkg::QW:0] range;
  logic [aux_out_pkg::QW-1:0] result;
  modport src (output value, output range, input result);
  modport calc (input value, input range, output result);
endinterface
`default_nettype wire

/* File: design/hyst_step.sv */
// Next state of a two-threshold comparator with hysteresis.
`timescale 1ns/1ps
`default_nettype none
module hyst_step #(
  parameter int W = 16
) (
  input wire logic [W-1:0] value,
  input wire logic [W-1:0] upper,
  input wire logic [W-1:0] lower,
  input wire logic prev,
  output logic next
);
  // Upper wins if the thresholds are set the wrong way round.
  always_comb begin
    if (value > upper) begin
      next = 1'b1;
    end else if (value < lower) begin
      next = 1'b0;
    end else begin
      next = prev;
    end
  end
endmodule
`default_nettype wire

/* File: design/saturating_scaler.sv */
// Linear scaler from a quantity and its range to a full-scale code.
`timescale 1ns/1ps
`default_nettype none
module saturating_scaler (
  scale_if.calc sc
);
  logic [31:0] prod;
  logic [31:0] quot;
  // A wide divide keeps the ratio exact; it costs area, not cycles.
  always_comb begin
    prod = {16'h0000, sc.value} * 32'h0000FFFF;
    quot = 32'h00000000;
    sc.result = aux_out_pkg::QTY_RESET;
    if (sc.range == 17'h00000) begin
      if (sc.value != aux_out_pkg::QTY_RESET) begin
        sc.result = aux_out_pkg::FULL_SCALE;
      end
    end else begin
      quot = prod / {15'h0000, sc.range};
      if (quot > {16'h0000, aux_out_pkg::FULL_SCALE}) begin
        sc.result = aux_out_pkg::FULL_SCALE;
      end else begin
        sc.result = quot[15:0];
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/aux_indicator.sv */
// Indicator model that latches the auxiliary digital level each cycle.
`timescale 1ns/1ps
`default_nettype none
module aux_indicator (
  input wire logic clk,
  input wire logic rstn,
  input wire logic level,
  output logic lamp
);
  // A real lamp input only sees the level one clock late.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lamp <= 1'b0;
    end else begin
      lamp <= level;
    end
  end
endmodule
`default_nettype wire

/* File: sim/aux_output_function_selector_tb_top.sv */
// Self-checking bench for the auxiliary output function selector.
`timescale 1ns/1ps
`default_nettype none
module aux_output_function_selector_tb_top;
  localparam int UC = 4;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, dig, mode, lamp;
  logic en = 1'b0, run = 1'b0, flt = 1'b0;
  logic [15:0] f = 16'h0000, sp = 16'h0000, cur = 16'h0000;
  logic [15:0] tq = 16'h0000, ain = 16'h0000, aval;
  logic [1:0] fmt_o;
  int bad_count = 0, compares = 0, cyc = 0;
  int m_sel = 0, m_fmt = 0, m_up = 0, m_lo = 0, m_rat = 0, m_max = 0, h = 0;
  int tbl[8] = '{1200, 800, 400, 800, 1000, 1001, 500, 499};

  aux_output_function_selector #(.UPDATE_CYCLES(UC))
    aux_output_function_selector_i (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .drive_enabled(en),
    .drive_running(run), .drive_fault(flt), .out_freq(f),
    .setpoint_freq(sp), .motor_current(cur), .motor_torque(tq),
    .analog_in2(ain), .aux_digital_out(dig), .aux_analog_mode(mode),
    .aux_analog_value(aval), .aux_format(fmt_o));
  aux_indicator aux_indicator_i (.clk(clk), .rstn(rstn), .level(dig),
    .lamp(lamp));

  always #10 clk = ~clk;

  task automatic finish_test();
    if (bad_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // The ceiling leaves ample room over the roughly two thousand six hundred cycles used.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    compares++;
    if (g !== x) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk("write error", 32'h00000000, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x,
                     input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk("prdata", x, r);
    chk("read error", xe, e);
  endtask

  function automatic longint scale(longint v, longint rng);
    longint s;
    if (rng == 0) begin
      return (v > 0) ? 65535 : 0;
    end
    s = v * 65535 / rng;
    return (s > 65535) ? 65535 : s;
  endfunction

  function automatic logic [17:0] model();
    longint q;
    longint v;
    logic d;
    q = (m_sel == 4) ? f : (m_sel == 5) ? cur : (m_sel == 6) ? tq : ain;
    if (m_sel >= 4 && m_sel <= 7) begin
      h = (q > m_up) ? 1 : (q < m_lo) ? 0 : h;
    end
    case (m_sel)
      0: d = en & run;
      1: d = !flt;
      2: d = (f == sp);
      3: d = (f > 0);
      4, 5, 6, 7: d = (h != 0);
      default: d = 1'b0;
    endcase
    v = (m_sel == 8) ? scale(f, m_max) : (m_sel == 9) ?
        scale(cur, 2 * m_rat) : (m_sel == 10) ? scale(tq, 1650) : 0;
    return {v[15:0], m_sel >= 8, d};
  endfunction

  // Two full update periods guarantee at least one tick saw every change.
  task automatic check();
    logic [17:0] x;
    repeat (2 * UC + 2) @(posedge clk);
    x = model();
    chk("digital", x[0], dig);
    chk("mode", x[1], mode);
    chk("value", x[17:2], aval);
    chk("format", m_fmt, fmt_o);
    chk("lamp", x[0], lamp);
    rdc(aux_out_pkg::OFS_STATUS, {x[17:2], 14'h0000, x[1:0]}, 1'b0);
  endtask

  task automatic trial(input int s);
    logic [15:0] fv;
    wr(aux_out_pkg::OFS_FUNC, 32'h00000000);
    m_sel = 0;
    m_fmt = $urandom_range(0, 3);
    m_up = $urandom_range(0, 4095);
    m_lo = $urandom_range(0, 4095);
    m_rat = $urandom_range(0, 2047);
    m_max = $urandom_range(0, 4095);
    wr(aux_out_pkg::OFS_FORMAT, {30'($urandom), 2'(m_fmt)});
    wr(aux_out_pkg::OFS_UPPER, {16'($urandom), 16'(m_up)});
    wr(aux_out_pkg::OFS_LOWER, {16'($urandom), 16'(m_lo)});
    wr(aux_out_pkg::OFS_RATED_CUR, {16'($urandom), 16'(m_rat)});
    wr(aux_out_pkg::OFS_MAX_FREQ, {16'($urandom), 16'(m_max)});
    rdc(aux_out_pkg::OFS_UPPER, 32'(m_up), 1'b0);
    fv = $urandom_range(0, 1) ? 16'h0000 : 16'($urandom_range(1, 4095));
    f <= fv;
    sp <= $urandom_range(0, 1) ? fv : 16'($urandom_range(0, 4095));
    en <= 1'($urandom);
    run <= 1'($urandom);
    flt <= 1'($urandom);
    cur <= 16'($urandom_range(0, 4095));
    tq <= 16'($urandom_range(0, 4095));
    ain <= 16'($urandom_range(0, 4095));
    check();
    wr(aux_out_pkg::OFS_FUNC, {28'($urandom), 4'(s)});
    m_sel = s;
    h = 0;
    check();
  endtask

  initial begin
    logic [31:0] r;
    logic e;
    void'($urandom(861));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rdc(8'(i * 4), 32'h00000000, 1'b0);
    end
    rdc(8'h1C, 32'h00000000, 1'b1);
    apb(1'b1, 8'h1C, 32'hFFFFFFFF, r, e);
    chk("unmapped write error", 32'h00000001, e);
    apb(1'b1, aux_out_pkg::OFS_STATUS, 32'hFFFFFFFF, r, e);
    chk("status write error", 32'h00000000, e);
    for (int k = 0; k < 48; k++) begin
      trial(k % 16);
    end
    m_up = 1000;
    m_lo = 500;
    wr(aux_out_pkg::OFS_UPPER, 32'(m_up));
    wr(aux_out_pkg::OFS_LOWER, 32'(m_lo));
    wr(aux_out_pkg::OFS_FUNC, 32'(aux_out_pkg::SEL_CUR_LIMIT));
    m_sel = 5;
    h = 0;
    foreach (tbl[i]) begin
      cur <= 16'(tbl[i]);
      check();
    end
    m_rat = 100;
    wr(aux_out_pkg::OFS_RATED_CUR, 32'(m_rat));
    wr(aux_out_pkg::OFS_FUNC, 32'(aux_out_pkg::SEL_ANALOG_CUR));
    m_sel = 9;
    cur <= 16'h012C;
    check();
    finish_test();
  end
endmodule
`default_nettype wire
